// file: rtl/cpml_map.svh
`ifndef CPML_MAP_SVH
`define CPML_MAP_SVH
// band codes from the select decoder
`define CPML_BAND_TOP 2'h3
`define CPML_BAND_UPPER 2'h2
`define CPML_BAND_LOWER 2'h1
`define CPML_BAND_BOTTOM 2'h0
// battery window comparator index
`define CPML_VB_MIN_EARLY 0
`define CPML_VB_MIN_HI_LATE 1
`define CPML_VB_MIN_LO_LATE 2
`define CPML_VB_MAX_HI 3
`define CPML_VB_MAX_LO 4
`define CPML_VB_CMP_W 5
// slope base interval: 56 s at an 80 min safety timer
`define CPML_BASE_SEC 56
`define CPML_SAFETY_MIN 80
// initial timer is safety timer divided by this
`define CPML_INIT_DIV 80
// default safety timer in clock cycles (80 min at 125 MHz)
`define CPML_SAFETY_CYC 64'd600000000000
`endif

// file: rtl/cpml_pkg.sv
`default_nettype none
package cpml_pkg;
  typedef enum logic [1:0] {
    CPML_IDLE = 2'b00,
    CPML_FAST = 2'b01,
    CPML_SUSPEND = 2'b10,
    CPML_DONE = 2'b11
  } cpml_state_t;
  typedef logic [1:0] cpml_band_t;
endpackage
`default_nettype wire

// file: rtl/cpml_band_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpml_map.svh"
// four-band thermometer decode of the selection input comparators
module cpml_band_decode (
  // comparator outputs, high when select is above each threshold
  input wire logic above_vcc_m03,
  input wire logic above_half_p04,
  input wire logic above_1v4,
  // decoded band
  output var cpml_pkg::cpml_band_t band
);
  // highest comparator set wins
  always_comb begin
    if (above_vcc_m03) begin
      band = `CPML_BAND_TOP;
    end else if (above_half_p04) begin
      band = `CPML_BAND_UPPER;
    end else if (above_1v4) begin
      band = `CPML_BAND_LOWER;
    end else begin
      band = `CPML_BAND_BOTTOM;
    end
  end
endmodule // cpml_band_decode
`default_nettype wire

// file: rtl/cpml_protect.sv
// Operation
// - The select input decodes into four bands picking window and policy.
// - Upper bands take 0.16-2.7 V before init timeout, 0.69-2.7 V after.
// - Lower bands take 0.16-2 V before init timeout, 1.2-2 V after.
// - Top and second-lowest bands suspend when too cold or too hot.
// - In suspending bands hot suspension latches, cold suspension does not.
// - The second-highest band treats too hot as charge completion.
// - The second-highest band drops slope termination when too cold.
// - Sense below 0.29 of supply is too hot, above 0.72 is too cold.
// - After the initial timer, fast charge stops when the sense fall per interval tops the threshold.
// - The slope interval is 56 s at an 80 min safety timer, scaled with it.
// - The initial timer ends one eightieth of the safety timer after start.
// - The initial and slope timers are held in reset during suspension.
`timescale 1ns/1ps
`default_nettype none
`include "cpml_map.svh"
module cpml_protect #(
  parameter int SAMPLE_W = 10,
  parameter logic [63:0] SAFETY_CYC = `CPML_SAFETY_CYC
) (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst,
  // selection band comparators
  input wire logic sel_above_vcc_m03,
  input wire logic sel_above_half_p04,
  input wire logic sel_above_1v4,
  // battery sense window comparators, one per threshold
  input wire logic [`CPML_VB_CMP_W-1:0] vb_above,
  // temperature sense comparators against 0.29 and 0.72 of supply
  input wire logic ts_below_029,
  input wire logic ts_above_072,
  // digitised temperature sense and slope threshold from adjust input
  input wire logic [SAMPLE_W-1:0] ts_sample,
  input wire logic [SAMPLE_W-1:0] slope_threshold,
  // fast charge start request after pre-qualifying
  input wire logic start_fast,
  // status
  output logic fast_charging,
  output logic suspended,
  output logic completed,
  output logic slope_enabled,
  output logic init_done,
  output logic hot_latched
);
  localparam logic [63:0] INIT_CYC = SAFETY_CYC / `CPML_INIT_DIV;
  localparam logic [63:0] BASE_CYC =
    SAFETY_CYC * `CPML_BASE_SEC / (64'd60 * `CPML_SAFETY_MIN);

  cpml_pkg::cpml_band_t band;
  cpml_pkg::cpml_state_t state_reg;
  cpml_pkg::cpml_state_t state_next;
  logic [63:0] init_cnt_reg;
  logic [63:0] base_cnt_reg;
  logic [SAMPLE_W-1:0] base_sample_reg;
  logic base_valid_reg;
  logic hot_latch_reg;
  logic vb_ok;
  logic too_hot;
  logic too_cold;
  logic suspend_band;
  logic suspend_cond;
  logic slope_trip;
  logic slope_en;
  logic hot_done;

  cpml_band_decode u_dec (
    .above_vcc_m03(sel_above_vcc_m03),
    .above_half_p04(sel_above_half_p04),
    .above_1v4(sel_above_1v4),
    .band(band)
  );

  // temperature limits: falling sense means rising temperature
  assign too_hot = ts_below_029;
  assign too_cold = ts_above_072;

  // battery window chosen by band pair and initial timer
  always_comb begin
    if (band[1]) begin
      vb_ok = !vb_above[`CPML_VB_MAX_HI] && (init_done ?
        vb_above[`CPML_VB_MIN_HI_LATE] :
        vb_above[`CPML_VB_MIN_EARLY]);
    end else begin
      vb_ok = !vb_above[`CPML_VB_MAX_LO] && (init_done ?
        vb_above[`CPML_VB_MIN_LO_LATE] :
        vb_above[`CPML_VB_MIN_EARLY]);
    end
  end

  // temperature policy per band
  assign suspend_band = (band == `CPML_BAND_TOP) ||
                        (band == `CPML_BAND_LOWER);
  assign suspend_cond = !vb_ok || hot_latch_reg ||
                        (suspend_band && (too_hot || too_cold));
  assign hot_done = (band == `CPML_BAND_UPPER) && too_hot;
  assign slope_en = !((band == `CPML_BAND_UPPER) && too_cold);
  assign slope_trip = slope_en && base_valid_reg && init_done &&
    (base_cnt_reg == BASE_CYC - 64'd1) && (ts_sample < base_sample_reg) &&
    ((base_sample_reg - ts_sample) > slope_threshold);

  // over-temperature latch, cleared only by power-on reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hot_latch_reg <= 1'b0;
    end else if (suspend_band && too_hot) begin
      hot_latch_reg <= 1'b1;
    end
  end

  // charge state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpml_pkg::CPML_IDLE: begin
        if (suspend_cond) state_next = cpml_pkg::CPML_SUSPEND;
        else if (start_fast) state_next = cpml_pkg::CPML_FAST;
      end
      cpml_pkg::CPML_FAST: begin
        if (suspend_cond) state_next = cpml_pkg::CPML_SUSPEND;
        else if (hot_done || slope_trip) state_next = cpml_pkg::CPML_DONE;
      end
      cpml_pkg::CPML_SUSPEND: begin
        if (!suspend_cond) state_next = cpml_pkg::CPML_IDLE;
      end
      cpml_pkg::CPML_DONE: state_next = cpml_pkg::CPML_DONE;
      default: state_next = cpml_pkg::CPML_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= cpml_pkg::CPML_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // initial timer, cleared outside fast charge and on leaving it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      init_cnt_reg <= 64'h0;
      init_done <= 1'b0;
    end else if (state_reg != cpml_pkg::CPML_FAST ||
                 state_next != cpml_pkg::CPML_FAST) begin
      init_cnt_reg <= 64'h0;
      init_done <= 1'b0;
    end else if (init_cnt_reg < INIT_CYC - 64'd1) begin
      init_cnt_reg <= init_cnt_reg + 64'd1;
    end else begin
      init_done <= 1'b1;
    end
  end

  // slope base interval sampling
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_cnt_reg <= 64'h0;
      base_sample_reg <= '0;
      base_valid_reg <= 1'b0;
    end else if (state_reg != cpml_pkg::CPML_FAST || !slope_en ||
                 state_next != cpml_pkg::CPML_FAST) begin
      base_cnt_reg <= 64'h0;
      base_sample_reg <= ts_sample;
      base_valid_reg <= 1'b0;
    end else if (base_cnt_reg == BASE_CYC - 64'd1) begin
      base_cnt_reg <= 64'h0;
      base_sample_reg <= ts_sample;
      base_valid_reg <= 1'b1;
    end else begin
      base_cnt_reg <= base_cnt_reg + 64'd1;
    end
  end

  // registered status outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_charging <= 1'b0;
      suspended <= 1'b0;
      completed <= 1'b0;
      slope_enabled <= 1'b0;
      hot_latched <= 1'b0;
    end else begin
      fast_charging <= (state_next == cpml_pkg::CPML_FAST);
      suspended <= (state_next == cpml_pkg::CPML_SUSPEND);
      completed <= (state_next == cpml_pkg::CPML_DONE);
      slope_enabled <= slope_en;
      hot_latched <= hot_latch_reg;
    end
  end

  property p_hot_latch;
    @(posedge clk_sys) disable iff (rst)
    (suspend_band && too_hot) |=> hot_latch_reg [*3];
  endproperty
  a_hot_latch: assert property (p_hot_latch)
    else $error("hot not latched");

  property p_susp_hold;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cpml_pkg::CPML_SUSPEND) |-> !init_done && !base_valid_reg;
  endproperty
  a_susp_hold: assert property (p_susp_hold)
    else $error("timers run in suspend");

  property p_upper_hot;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cpml_pkg::CPML_FAST && hot_done && !suspend_cond)
      |=> completed;
  endproperty
  a_upper_hot: assert property (p_upper_hot)
    else $error("hot not done");

  property p_cold_slope;
    @(posedge clk_sys) disable iff (rst)
    (band == `CPML_BAND_UPPER && too_cold) |=> !slope_enabled;
  endproperty
  a_cold_slope: assert property (p_cold_slope)
    else $error("slope on when cold");

  property p_susp_temp;
    @(posedge clk_sys) disable iff (rst)
    (suspend_band && (too_hot || too_cold) &&
      state_reg != cpml_pkg::CPML_DONE) |=> suspended;
  endproperty
  a_susp_temp: assert property (p_susp_temp)
    else $error("no temp suspend");

  property p_vb_bad;
    @(posedge clk_sys) disable iff (rst)
    (!vb_ok && state_reg != cpml_pkg::CPML_DONE) |=> suspended;
  endproperty
  a_vb_bad: assert property (p_vb_bad)
    else $error("no vb suspend");

  property p_init_zero;
    @(posedge clk_sys) disable iff (rst)
    $rose(init_done) |-> $past(init_cnt_reg) == INIT_CYC - 64'd1;
  endproperty
  a_init_zero: assert property (p_init_zero)
    else $error("init timer length");

  property p_slope_done;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cpml_pkg::CPML_FAST && slope_trip && !suspend_cond)
      |=> completed;
  endproperty
  a_slope_done: assert property (p_slope_done)
    else $error("slope no stop");

  // start of fast charge opens a fresh initial timer
  sequence s_idle_start;
    state_reg == cpml_pkg::CPML_IDLE && start_fast && !suspend_cond;
  endsequence
  sequence s_fast_fresh;
    fast_charging && !init_done && (init_cnt_reg == 64'h0);
  endsequence
  property p_init_start;
    @(posedge clk_sys) disable iff (rst)
    s_idle_start |=> s_fast_fresh;
  endproperty
  a_init_start: assert property (p_init_start)
    else $error("fast start timer not fresh");

  // timer counts stay cleared for the whole suspension
  sequence s_suspending;
    state_reg == cpml_pkg::CPML_SUSPEND;
  endsequence
  property p_susp_clear;
    @(posedge clk_sys) disable iff (rst)
    s_suspending |-> (init_cnt_reg == 64'h0) && (base_cnt_reg == 64'h0);
  endproperty
  a_susp_clear: assert property (p_susp_clear)
    else $error("timer count kept in suspend");

  // late lower-band window rejects a battery under its raised floor
  property p_lo_late;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cpml_pkg::CPML_FAST && !band[1] && init_done &&
      !vb_above[`CPML_VB_MIN_LO_LATE]) |=> suspended;
  endproperty
  a_lo_late: assert property (p_lo_late)
    else $error("low band late floor missed");

  // upper-band ceiling applies before and after the initial timer
  property p_hi_max;
    @(posedge clk_sys) disable iff (rst)
    (band[1] && vb_above[`CPML_VB_MAX_HI] &&
      state_reg != cpml_pkg::CPML_DONE) |=> suspended;
  endproperty
  a_hi_max: assert property (p_hi_max)
    else $error("high band ceiling missed");

  // base interval counter wraps at its length
  property p_base_wrap;
    @(posedge clk_sys) disable iff (rst)
    (base_cnt_reg == BASE_CYC - 64'd1) |=> (base_cnt_reg == 64'h0);
  endproperty
  a_base_wrap: assert property (p_base_wrap)
    else $error("slope interval length");

  // completion holds until reset
  property p_done_stick;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == cpml_pkg::CPML_DONE) |=> completed && !fast_charging;
  endproperty
  a_done_stick: assert property (p_done_stick)
    else $error("completion not held");

  // hot latch never drops while out of reset
  property p_latch_keep;
    @(posedge clk_sys) disable iff (rst)
    hot_latch_reg |=> hot_latch_reg && hot_latched;
  endproperty
  a_latch_keep: assert property (p_latch_keep)
    else $error("hot latch dropped");
endmodule // cpml_protect
`default_nettype wire

// file: test/cpml_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
// divider and thermistor network as seen through the comparators
module cpml_sense_model #(
  parameter int VCC_MV = 5000
) (
  // analog levels: select and battery in mV, sense in per mille
  input wire logic [15:0] sel_mv,
  input wire logic [15:0] vb_mv,
  input wire logic [15:0] ts_pm,
  // comparator levels and digitised sense
  output logic m03,
  output logic h04,
  output logic l14,
  output logic [4:0] vb_above,
  output logic hot,
  output logic cold,
  output logic [9:0] ts_sample
);
  // select band thresholds
  assign m03 = sel_mv > 16'(VCC_MV - 300);
  assign h04 = sel_mv > 16'(VCC_MV / 2 + 400);
  assign l14 = sel_mv > 16'h0578;
  // battery window thresholds
  assign vb_above = {vb_mv > 16'h07D0, vb_mv > 16'h0A8C, vb_mv > 16'h04B0,
                     vb_mv > 16'h02B2, vb_mv > 16'h00A0};
  // sense falls as temperature rises
  assign hot = ts_pm < 16'h0122;
  assign cold = ts_pm > 16'h02D0;
  assign ts_sample = ts_pm[9:0];
endmodule // cpml_sense_model
`default_nettype wire

// file: test/charge_protection_mode_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module charge_protection_mode_logic_tb_top;
  localparam int INIT = 600;
  localparam int BASE = 560;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start_fast = 1'b0;
  logic [15:0] sel_mv = 16'h1324;
  logic [15:0] vb_mv = 16'h03E8;
  logic [15:0] ts_pm = 16'h01F4;
  logic [9:0] thr = 10'h014;
  logic [15:0] band_mv [4] = '{16'h00C8, 16'h07D0, 16'h0CE4, 16'h1324};
  logic m03, h04, l14, hot, cold, fast, susp, done, slope, initd, hotl;
  logic [4:0] vb_above;
  logic [9:0] ts_sample;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;
  cpml_sense_model cpml_sense_model_inst (.sel_mv(sel_mv), .vb_mv(vb_mv),
    .ts_pm(ts_pm), .m03(m03), .h04(h04), .l14(l14), .vb_above(vb_above),
    .hot(hot), .cold(cold), .ts_sample(ts_sample));
  cpml_protect #(.SAFETY_CYC(64'd48000)) cpml_protect_inst (.clk_sys(clk_sys),
    .rst(rst), .sel_above_vcc_m03(m03), .sel_above_half_p04(h04),
    .sel_above_1v4(l14), .vb_above(vb_above), .ts_below_029(hot),
    .ts_above_072(cold), .ts_sample(ts_sample), .slope_threshold(thr),
    .start_fast(start_fast), .fast_charging(fast), .suspended(susp),
    .completed(done), .slope_enabled(slope), .init_done(initd),
    .hot_latched(hotl));
  task automatic chk(input string nm, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic do_reset(input logic [15:0] s, input logic [15:0] v);
    rst = 1'b1;
    start_fast = 1'b0;
    sel_mv = s;
    vb_mv = v;
    ts_pm = 16'h01F4;
    wait_n(16);
    rst = 1'b0;
    wait_n(1);
  endtask
  task automatic go;
    start_fast = 1'b1;
    wait_n(2);
    start_fast = 1'b0;
  endtask
  // battery window per band, before and after the initial timer
  task automatic sc_window;
    for (int b = 0; b < 4; b++) begin
      do_reset(band_mv[b], 16'h03E8);
      go;
      chk("fast", fast, 1'b1);
      wait_n(INIT - 10);
      chk("init_early", initd, 1'b0);
      wait_n(9);
      chk("init", initd, 1'b1);
      wait_n(1);
      chk("susp_late", susp, b < 2);
      chk("fast_late", fast, b >= 2);
      wait_n(1);
      chk("late_rel", susp, 1'b0);
      do_reset(band_mv[b], 16'h0AF0);
      go;
      chk("susp_top", susp, 1'b1);
      do_reset(band_mv[b], 16'h09C4);
      go;
      chk("susp_high", susp, b < 2);
      do_reset(band_mv[b], 16'h0064);
      go;
      chk("susp_low", susp, 1'b1);
    end
  endtask
  // suspending bands: hot latches, cold releases
  task automatic sc_temp(input int b);
    do_reset(band_mv[b], 16'h03E8);
    go;
    ts_pm = 16'h0064;
    wait_n(3);
    chk("hot_susp", susp, 1'b1);
    chk("hot_latch", hotl, 1'b1);
    chk("hot_fast", fast, 1'b0);
    ts_pm = 16'h01F4;
    wait_n(3);
    go;
    chk("latched", susp, 1'b1);
    chk("latched_fast", fast, 1'b0);
    do_reset(band_mv[b], 16'h03E8);
    go;
    ts_pm = 16'h0320;
    wait_n(3);
    chk("cold_susp", susp, 1'b1);
    chk("cold_latch", hotl, 1'b0);
    ts_pm = 16'h01F4;
    wait_n(3);
    chk("cold_free", susp, 1'b0);
    go;
    chk("restart", fast, 1'b1);
  endtask
  // second-highest band: hot completes, cold drops slope
  task automatic sc_upper;
    do_reset(band_mv[2], 16'h03E8);
    go;
    ts_pm = 16'h0064;
    wait_n(3);
    chk("hot_done", done, 1'b1);
    chk("hot_nosusp", susp, 1'b0);
    do_reset(band_mv[2], 16'h03E8);
    go;
    wait_n(INIT + 10);
    chk("slope_on", slope, 1'b1);
    ts_pm = 16'h0320;
    wait_n(3);
    chk("slope_off", slope, 1'b0);
    chk("cold_nosusp", susp, 1'b0);
  endtask
  // slope termination over the base interval
  task automatic sc_slope;
    do_reset(band_mv[3], 16'h03E8);
    go;
    wait_n(INIT + 10);
    ts_pm = 16'h01EF;
    wait_n(2 * BASE + 10);
    chk("small_fall", done, 1'b0);
    ts_pm = 16'h01BD;
    wait_n(2 * BASE + 10);
    chk("big_fall", done, 1'b1);
    chk("big_fast", fast, 1'b0);
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      finish_test;
    end
  end
  // main sequence
  initial begin
    sc_window;
    sc_temp(3);
    sc_temp(1);
    sc_upper;
    sc_slope;
    finish_test;
  end
endmodule // charge_protection_mode_logic_tb_top
`default_nettype wire
